// ### hw/asd_cfg.svh
// Opcodes, field positions, reset values and state counts of the add/subtract datapath
`ifndef ASD_CFG_SVH
`define ASD_CFG_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define ASD_OP_STORE_PAIR_DIRECT 8'h22
`define ASD_OP_LOAD_ACC_IND_BC 8'h0A
`define ASD_OP_LOAD_ACC_IND_DE 8'h1A
`define ASD_OP_INC_MEM 8'h34

// ----------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------
`define ASD_GRP_HI 7
`define ASD_GRP_LO 6
`define ASD_DST_HI 5
`define ASD_DST_LO 3
`define ASD_SRC_HI 2
`define ASD_SRC_LO 0
`define ASD_GRP_ARITH 2'h2
`define ASD_GRP_IMM 2'h3
`define ASD_GRP_INC 2'h0
`define ASD_LOW_IMM 3'h6
`define ASD_LOW_INC 3'h4
`define ASD_SEL_B 3'h0
`define ASD_SEL_C 3'h1
`define ASD_SEL_D 3'h2
`define ASD_SEL_E 3'h3
`define ASD_SEL_H 3'h4
`define ASD_SEL_L 3'h5
`define ASD_SEL_MEM 3'h6
`define ASD_SEL_A 3'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ASD_RST_PC 16'h0000
`define ASD_RST_REG 8'h00
`define ASD_RST_FLAGS 5'h00

// ----------------------------------------------------------------
// States per machine cycle, as last state index, and the state index at which fetch samples read data
// ----------------------------------------------------------------
`define ASD_FETCH_LAST 2'h3
`define ASD_CYCLE_LAST 2'h2
`define ASD_READ_SAMPLE 2'h2

`endif

// ### hw/asd_pkg.sv
// Types shared by the add/subtract datapath
package asd_pkg;

	typedef enum logic [2:0] {
		MC_IDLE = 3'h0,
		MC_FETCH = 3'h1,
		MC_IMM = 3'h2,
		MC_ADLO = 3'h3,
		MC_ADHI = 3'h4,
		MC_MEMRD = 3'h5,
		MC_MEMWR = 3'h6,
		MC_WRHI = 3'h7
	} asd_mcyc_type;

	typedef enum logic [2:0] {
		ALU_ADD = 3'h0,
		ALU_ADC = 3'h1,
		ALU_SUB = 3'h2,
		ALU_SBB = 3'h3,
		ALU_INC = 3'h4
	} asd_alu_op_type;

	typedef struct packed {
		logic sign;
		logic zero;
		logic half_carry_flag;
		logic parity;
		logic carry_flag;
	} asd_flags_type;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} asd_bus_type;

	typedef struct packed {
		asd_mcyc_type mcyc;
		logic [1:0] tcnt;
		logic [15:0] pc;
		logic [15:0] tmp_addr;
		logic [7:0] opcode;
		logic [7:0][7:0] regs;
		asd_flags_type flags;
		asd_bus_type bus;
		logic done;
		logic illegal;
	} asd_state_type;

endpackage

// ### hw/asd_flag_gen.sv
// Zero, sign and even-parity flags of an 8-bit result
`timescale 1ns/1ns
module asd_flag_gen
	import asd_pkg::*;
(
	input wire logic [7:0] res_i,
	output logic zero_o,
	output logic sign_o,
	output logic parity_o
);

	assign zero_o = (res_i == 8'h00);
	assign sign_o = res_i[7];
	assign parity_o = ~(^res_i);

endmodule

// ### hw/asd_alu.sv
// 8-bit adder/subtractor with carry, borrow and half carry
`timescale 1ns/1ns
module asd_alu
	import asd_pkg::*;
(
	input asd_alu_op_type op_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic carry_i,
	output logic [7:0] res_o,
	output logic carry_o,
	output logic half_o
);

	logic is_sub;
	logic [7:0] b_eff;
	logic c_eff;
	logic [8:0] sum9;
	logic [4:0] sum5;

	// Subtraction runs as a + ~b + ~borrow; carry out inverted gives borrow
	assign is_sub = (op_i == ALU_SUB) || (op_i == ALU_SBB);
	assign b_eff = (op_i == ALU_INC) ? 8'h00 : (is_sub ? ~b_i : b_i);
	always_comb begin
		case (op_i)
			ALU_ADD: c_eff = 1'b0;
			ALU_ADC: c_eff = carry_i;
			ALU_SUB: c_eff = 1'b1;
			ALU_SBB: c_eff = ~carry_i;
			ALU_INC: c_eff = 1'b1;
			default: c_eff = 1'b0;
		endcase
	end
	assign sum9 = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, c_eff};
	assign sum5 = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
	assign res_o = sum9[7:0];
	assign carry_o = is_sub ? ~sum9[8] : sum9[8]; // RL18
	assign half_o = sum5[4]; // RL20

endmodule

// ### hw/asd_core.sv
// Instruction sequencer and register file for the add/subtract datapath subset
// Operation
// RL1: Store pair direct: opcode, address low, high; writes L there; 5 cycles, 16 states.
// RL2: Store pair direct writes H at the address one above L's.
// RL3: Load accumulator indirect via BC or DE only; 2 cycles, 7 states, flags kept.
// RL4: Add register into accumulator; 1 cycle, 4 states, all five flags.
// RL5: Add byte at HL into accumulator; 2 cycles, 7 states, all flags.
// RL6: Add second instruction byte into accumulator; 2 cycles, 7 states, all flags.
// RL7: Add register plus carry into accumulator; 1 cycle, 4 states, all flags.
// RL8: Add byte at HL plus carry into accumulator; 2 cycles, 7 states.
// RL9: Add second byte plus carry into accumulator; 2 cycles, 7 states.
// RL10: Subtract register from accumulator; 1 cycle, 4 states, all flags.
// RL11: Subtract byte at HL from accumulator; 2 cycles, 7 states.
// RL12: Subtract second byte from accumulator; 2 cycles, 7 states.
// RL13: Subtract second byte and carry from accumulator; 2 cycles, 7 states.
// RL14: Subtract register and carry from accumulator; 1 cycle, 4 states.
// RL15: Subtract byte at HL and carry from accumulator; 2 cycles, 7 states.
// RL16: Increment register; 1 cycle, 4 states; carry kept, other flags updated.
// RL17: Increment byte at HL in memory; 3 cycles, 10 states; carry kept.
// RL18: Subtraction is two's complement; carry set on borrow, cleared otherwise.
// RL19: Arithmetic updates zero, sign, parity, carry, half carry by standard rules.
// RL20: Zero on zero result, sign is bit 7, parity even, half carry from bit 3.
// RL21: Register selector codes 0 to 7: B, C, D, E, H, L, memory, A.
`timescale 1ns/1ns
`include "asd_cfg.svh"
module asd_core
	import asd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic run_i,
	input wire logic reg_load_i,
	input wire logic [2:0] reg_load_sel_i,
	input wire logic [7:0] reg_load_data_i,
	input wire logic pc_load_i,
	input wire logic [15:0] pc_load_data_i,
	input wire logic flags_load_i,
	input asd_flags_type flags_load_data_i,
	input wire logic [7:0] mem_rdata_i,
	output logic [15:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [7:0] mem_wdata_o,
	output logic cycle_start_o,
	output logic instr_done_o,
	output logic illegal_op_o,
	output logic [15:0] pc_o,
	output logic [7:0] acc_o,
	output asd_flags_type flags_o,
	output logic [7:0][7:0] regs_o
);

	// ----------------------------------------------------------------
	// State and operand selection
	// ----------------------------------------------------------------
	asd_state_type state_reg;
	asd_state_type state_next;

	logic [1:0] op_grp;
	logic [2:0] op_dst;
	logic [2:0] op_src;
	logic is_arith_reg;
	logic is_arith_imm;
	logic is_inc;
	asd_alu_op_type alu_op;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic [7:0] alu_res;
	logic alu_carry;
	logic alu_half;
	logic res_zero;
	logic res_sign;
	logic res_parity;
	asd_flags_type alu_flags;
	logic [15:0] hl_addr;
	logic [15:0] bc_addr;
	logic [15:0] de_addr;
	logic is_store_pair;
	logic is_load_bc;
	logic is_load_de;
	logic last;

	// ----------------------------------------------------------------
	// Opcode decode
	// ----------------------------------------------------------------
	assign op_grp = state_reg.opcode[`ASD_GRP_HI:`ASD_GRP_LO];
	assign op_dst = state_reg.opcode[`ASD_DST_HI:`ASD_DST_LO];
	assign op_src = state_reg.opcode[`ASD_SRC_HI:`ASD_SRC_LO];
	// Only add, carry add, subtract and borrow subtract of the arithmetic row
	assign is_arith_reg = (op_grp == `ASD_GRP_ARITH) && !op_dst[2];
	assign is_arith_imm = (op_grp == `ASD_GRP_IMM) && (op_src == `ASD_LOW_IMM) && !op_dst[2];
	assign is_inc = (op_grp == `ASD_GRP_INC) && (op_src == `ASD_LOW_INC);
	assign is_store_pair = (state_reg.opcode == `ASD_OP_STORE_PAIR_DIRECT);
	assign is_load_bc = (state_reg.opcode == `ASD_OP_LOAD_ACC_IND_BC);
	assign is_load_de = (state_reg.opcode == `ASD_OP_LOAD_ACC_IND_DE);
	assign hl_addr = {state_reg.regs[`ASD_SEL_H], state_reg.regs[`ASD_SEL_L]};
	assign bc_addr = {state_reg.regs[`ASD_SEL_B], state_reg.regs[`ASD_SEL_C]};
	assign de_addr = {state_reg.regs[`ASD_SEL_D], state_reg.regs[`ASD_SEL_E]};

	// Arithmetic and immediate rows share the operation field
	always_comb begin
		case (op_dst[1:0])
			2'h0: alu_op = ALU_ADD;
			2'h1: alu_op = ALU_ADC;
			2'h2: alu_op = ALU_SUB;
			2'h3: alu_op = ALU_SBB;
			default: alu_op = ALU_ADD;
		endcase
		if (is_inc) begin
			alu_op = ALU_INC;
		end
	end

	// Fetch runs four states, every other machine cycle three
	always_comb begin
		case (state_reg.mcyc)
			MC_IDLE: last = 1'b0;
			MC_FETCH: last = (state_reg.tcnt == `ASD_FETCH_LAST);
			default: last = (state_reg.tcnt == `ASD_CYCLE_LAST);
		endcase
	end

	// ----------------------------------------------------------------
	// Datapath
	// ----------------------------------------------------------------
	// Register-form sources come from the file, others from the data bus
	always_comb begin
		alu_a = state_reg.regs[`ASD_SEL_A];
		alu_b = mem_rdata_i;
		if (is_inc) begin
			alu_a = (op_dst == `ASD_SEL_MEM) ? mem_rdata_i : state_reg.regs[op_dst]; // RL21
			alu_b = 8'h00;
		end else if (state_reg.mcyc == MC_FETCH) begin
			alu_b = state_reg.regs[op_src]; // RL21
		end
	end

	asd_alu u_alu (
		.op_i(alu_op),
		.a_i(alu_a),
		.b_i(alu_b),
		.carry_i(state_reg.flags.carry_flag),
		.res_o(alu_res),
		.carry_o(alu_carry),
		.half_o(alu_half)
	);

	asd_flag_gen u_flag_gen (
		.res_i(alu_res),
		.zero_o(res_zero),
		.sign_o(res_sign),
		.parity_o(res_parity)
	);

	// ----------------------------------------------------------------
	// Flag update
	// ----------------------------------------------------------------
	always_comb begin
		alu_flags.sign = res_sign; // RL20
		alu_flags.zero = res_zero; // RL20
		alu_flags.half_carry_flag = alu_half; // RL20
		alu_flags.parity = res_parity; // RL20
		alu_flags.carry_flag = alu_carry; // RL19
		if (is_inc) begin
			alu_flags.carry_flag = state_reg.flags.carry_flag; // RL16
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	function automatic asd_state_type start_cycle(input asd_state_type s, input asd_mcyc_type mc,
		input logic [15:0] addr, input logic rd, input logic wr, input logic [7:0] wdata);
		asd_state_type r;
		r = s;
		r.mcyc = mc;
		r.tcnt = 2'h0;
		r.bus.addr = addr;
		r.bus.rd = rd;
		r.bus.wr = wr;
		r.bus.wdata = wdata;
		return r;
	endfunction

	always_comb begin
		logic fin;
		fin = 1'b0;
		state_next = state_reg;
		state_next.done = 1'b0;
		state_next.illegal = 1'b0;
		if (state_reg.mcyc != MC_IDLE) begin
			state_next.tcnt = state_reg.tcnt + 2'h1;
		end
		case (state_reg.mcyc)
			MC_IDLE: begin
				// Host loads are taken only while the sequencer is idle
				if (reg_load_i) begin
					state_next.regs[reg_load_sel_i] = reg_load_data_i;
				end
				if (pc_load_i) begin
					state_next.pc = pc_load_data_i;
				end
				if (flags_load_i) begin
					state_next.flags = flags_load_data_i;
				end
				if (run_i) begin
					state_next = start_cycle(state_next, MC_FETCH, state_next.pc, 1'b1, 1'b0, 8'h00);
				end
			end
			MC_FETCH: begin
				if (state_reg.tcnt == `ASD_READ_SAMPLE) begin
					state_next.opcode = mem_rdata_i;
					state_next.pc = state_reg.pc + 16'h0001;
					state_next.bus.rd = 1'b0;
				end else if (last) begin
					if (is_store_pair) begin
						state_next = start_cycle(state_next, MC_ADLO, state_reg.pc, 1'b1, 1'b0, 8'h00); // RL1
					end else if (is_load_bc) begin
						state_next = start_cycle(state_next, MC_MEMRD, bc_addr, 1'b1, 1'b0, 8'h00); // RL3
					end else if (is_load_de) begin
						state_next = start_cycle(state_next, MC_MEMRD, de_addr, 1'b1, 1'b0, 8'h00); // RL3
					end else if (is_arith_imm) begin
						state_next = start_cycle(state_next, MC_IMM, state_reg.pc, 1'b1, 1'b0, 8'h00); // RL6
					end else if (is_arith_reg && (op_src == `ASD_SEL_MEM)) begin
						state_next = start_cycle(state_next, MC_MEMRD, hl_addr, 1'b1, 1'b0, 8'h00); // RL5
					end else if (is_inc && (op_dst == `ASD_SEL_MEM)) begin
						state_next = start_cycle(state_next, MC_MEMRD, hl_addr, 1'b1, 1'b0, 8'h00); // RL17
					end else if (is_arith_reg) begin
						// Register forms finish in the fourth state
						state_next.regs[`ASD_SEL_A] = alu_res; // RL4 RL7 RL10 RL14
						state_next.flags = alu_flags; // RL19
						fin = 1'b1;
					end else if (is_inc) begin
						state_next.regs[op_dst] = alu_res; // RL16
						state_next.flags = alu_flags; // RL16
						fin = 1'b1;
					end else begin
						state_next.illegal = 1'b1;
						fin = 1'b1;
					end
				end
			end
			MC_IMM: begin
				if (last) begin
					state_next.pc = state_reg.pc + 16'h0001;
					state_next.regs[`ASD_SEL_A] = alu_res; // RL6 RL9 RL12 RL13
					state_next.flags = alu_flags; // RL19
					fin = 1'b1;
				end
			end
			MC_ADLO: begin
				if (last) begin
					state_next.tmp_addr[7:0] = mem_rdata_i;
					state_next.pc = state_reg.pc + 16'h0001;
					state_next = start_cycle(state_next, MC_ADHI, state_next.pc, 1'b1, 1'b0, 8'h00); // RL1
				end
			end
			MC_ADHI: begin
				if (last) begin
					state_next.tmp_addr[15:8] = mem_rdata_i;
					state_next.pc = state_reg.pc + 16'h0001;
					state_next = start_cycle(state_next, MC_MEMWR, {mem_rdata_i, state_reg.tmp_addr[7:0]},
						1'b0, 1'b1, state_reg.regs[`ASD_SEL_L]); // RL1
				end
			end
			MC_MEMRD: begin
				if (last) begin
					if (is_inc) begin
						state_next.flags = alu_flags; // RL17
						state_next = start_cycle(state_next, MC_MEMWR, state_reg.bus.addr, 1'b0, 1'b1, alu_res); // RL17
					end else if (is_arith_reg) begin
						state_next.regs[`ASD_SEL_A] = alu_res; // RL5 RL8 RL11 RL15
						state_next.flags = alu_flags; // RL19
						fin = 1'b1;
					end else begin
						state_next.regs[`ASD_SEL_A] = mem_rdata_i; // RL3
						fin = 1'b1;
					end
				end
			end
			MC_MEMWR: begin
				if (last) begin
					if (state_reg.opcode == `ASD_OP_STORE_PAIR_DIRECT) begin
						state_next = start_cycle(state_next, MC_WRHI, state_reg.bus.addr + 16'h0001,
							1'b0, 1'b1, state_reg.regs[`ASD_SEL_H]); // RL2
					end else begin
						fin = 1'b1;
					end
				end
			end
			MC_WRHI: begin
				if (last) begin
					fin = 1'b1;
				end
			end
			default: begin
				state_next = start_cycle(state_next, MC_IDLE, state_reg.pc, 1'b0, 1'b0, 8'h00);
			end
		endcase
		if (fin) begin
			state_next.done = 1'b1;
			if (run_i) begin
				state_next = start_cycle(state_next, MC_FETCH, state_next.pc, 1'b1, 1'b0, 8'h00);
			end else begin
				state_next = start_cycle(state_next, MC_IDLE, state_next.pc, 1'b0, 1'b0, 8'h00);
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg.mcyc <= MC_IDLE;
			state_reg.tcnt <= 2'h0;
			state_reg.pc <= `ASD_RST_PC;
			state_reg.tmp_addr <= 16'h0000;
			state_reg.opcode <= 8'h00;
			state_reg.regs <= {8{`ASD_RST_REG}};
			state_reg.flags <= `ASD_RST_FLAGS;
			state_reg.bus <= '0;
			state_reg.done <= 1'b0;
			state_reg.illegal <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Memory bus outputs
	// ----------------------------------------------------------------
	assign mem_addr_o = state_reg.bus.addr;
	assign mem_rd_o = state_reg.bus.rd;
	assign mem_wr_o = state_reg.bus.wr && (state_reg.tcnt != `ASD_FETCH_LAST);
	assign mem_wdata_o = state_reg.bus.wdata;
	assign cycle_start_o = (state_reg.mcyc != MC_IDLE) && (state_reg.tcnt == 2'h0);
	assign instr_done_o = state_reg.done;
	assign illegal_op_o = state_reg.illegal;

	// ----------------------------------------------------------------
	// Architectural state outputs
	// ----------------------------------------------------------------
	assign pc_o = state_reg.pc;
	assign acc_o = state_reg.regs[`ASD_SEL_A];
	assign flags_o = state_reg.flags;
	assign regs_o = state_reg.regs;

endmodule

// ### tb/asd_core_asserts.sv
// Port checks of the add/subtract datapath
`timescale 1ns/1ns
module asd_core_asserts
	import asd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic reg_load_i,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [7:0] mem_wdata_o,
	input wire logic cycle_start_o,
	input wire logic instr_done_o,
	input wire logic [7:0] acc_o,
	input wire logic [7:0][7:0] regs_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);

	rd_wr_excl_a: assert property (!(mem_rd_o && mem_wr_o))
		else $error("read and write strobes together");
	rd_hold_a: assert property (cycle_start_o && mem_rd_o |=> (mem_rd_o && $stable(mem_addr_o))[*2])
		else $error("read cycle not held");
	wr_hold_a: assert property (cycle_start_o && mem_wr_o |=>
		(mem_wr_o && $stable(mem_addr_o) && $stable(mem_wdata_o))[*2])
		else $error("write cycle not held");
	pair_high_a: assert property ((cycle_start_o && mem_wr_o) ##3 (cycle_start_o && mem_wr_o) |->
		mem_addr_o == $past(mem_addr_o, 3) + 16'h0001 && mem_wdata_o == regs_o[4])
		else $error("second pair write wrong");
	pair_low_a: assert property ((cycle_start_o && mem_wr_o) ##3 (cycle_start_o && mem_wr_o) |->
		$past(mem_wdata_o, 3) == regs_o[5])
		else $error("first pair write wrong");
	start_gap_a: assert property (cycle_start_o |=> !cycle_start_o [*2])
		else $error("machine cycle too short");
	done_span_a: assert property (instr_done_o |-> $past(cycle_start_o, 3) || $past(cycle_start_o, 4))
		else $error("done not at end of a machine cycle");
	done_pulse_a: assert property (instr_done_o |=> !instr_done_o)
		else $error("done longer than one clock");
	acc_cause_a: assert property (!$stable(acc_o) |-> instr_done_o || $past(reg_load_i))
		else $error("accumulator changed mid instruction");
endmodule

bind asd_core asd_core_asserts u_asd_core_asserts (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
	.reg_load_i(reg_load_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
	.mem_wdata_o(mem_wdata_o), .cycle_start_o(cycle_start_o), .instr_done_o(instr_done_o),
	.acc_o(acc_o), .regs_o(regs_o));

// ### tb/asd_mem_model.sv
// Memory on the far side of the datapath bus
`timescale 1ns/1ns
module asd_mem_model (
	input wire logic sys_clk_i,
	input wire logic [15:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg = 8'h00;
	// Released bus shows the inverse of the last byte
	assign rdata_o = rd_i ? mem[addr_i] : ~last_reg;
	always @(posedge sys_clk_i) begin
		if (rd_i) begin
			last_reg <= rdata_o;
		end
		if (wr_i) begin
			mem[addr_i] <= wdata_i;
		end
	end
endmodule

// ### tb/asd_core_bench.sv
// Self-checking bench of the add/subtract datapath
`timescale 1ns/1ns
module asd_core_bench
	import asd_pkg::*;
;
	typedef struct packed {
		logic [2:0] sel;
		logic [15:0] addr;
		logic [7:0] val;
		logic [4:0] flg;
		logic [4:0] states;
		logic [15:0] pc;
	} asd_note_type;
	logic sys_clk_i, rstn_i, run_i, reg_load_i, pc_load_i, flags_load_i;
	logic mem_rd_o, mem_wr_o, cycle_start_o, instr_done_o, illegal_op_o, busy;
	logic [2:0] reg_load_sel_i;
	logic [7:0] reg_load_data_i, mem_rdata_i, mem_wdata_o, acc_o;
	logic [15:0] pc_load_data_i, mem_addr_o, pc_o, pc, sp_addr;
	asd_flags_type flags_load_data_i, flags_o;
	logic [7:0][7:0] regs_o;
	logic [7:0] img [0:65535];
	logic [7:0] r [0:7];
	logic [4:0] f;
	logic [31:0] lfsr_state = 32'hEED6;
	asd_note_type notes[$];
	asd_note_type nt;
	int n_errors = 0, comparisons = 0, ndone = 0, cnt = 0, cycles = 0;

	asd_core u_asd_core (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .run_i(run_i), .reg_load_i(reg_load_i),
		.reg_load_sel_i(reg_load_sel_i), .reg_load_data_i(reg_load_data_i), .pc_load_i(pc_load_i),
		.pc_load_data_i(pc_load_data_i), .flags_load_i(flags_load_i), .flags_load_data_i(flags_load_data_i),
		.mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
		.mem_wdata_o(mem_wdata_o), .cycle_start_o(cycle_start_o), .instr_done_o(instr_done_o),
		.illegal_op_o(illegal_op_o), .pc_o(pc_o), .acc_o(acc_o), .flags_o(flags_o), .regs_o(regs_o));
	asd_mem_model u_mem (.sys_clk_i(sys_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rnd();
		lfsr_state = {lfsr_state[30:0], 1'b0} ^ (lfsr_state[31] ? 32'h04C11DB7 : 32'h0);
		return lfsr_state[7:0];
	endfunction

	// Ops 0..3 add, carry add, sub, borrow sub; 4 increment keeping carry
	function automatic logic [12:0] alu(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] h;
		logic ci, cy;
		ci = (op == 3'h1 || op == 3'h3) ? f[0] : 1'b0;
		if (op == 3'h2 || op == 3'h3) begin
			s = {1'b0, a} + {1'b0, ~b} + {8'h00, ~ci};
			h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~ci};
			cy = ~s[8];
		end else begin
			s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
			cy = (op == 3'h4) ? f[0] : s[8];
		end
		return {s[7], s[7:0] == 8'h00, h[4], ~^s[7:0], cy, s[7:0]};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic put(input logic [15:0] a, input logic [7:0] v);
		img[a] = v;
		u_mem.mem[a] = v;
	endtask

	task automatic emit(input logic [7:0] v);
		put(pc, v);
		pc++;
	endtask

	task automatic note(input logic [2:0] sel, input logic [15:0] a, input logic [7:0] v, input logic [4:0] st);
		notes.push_back({sel, a, v, f, st, pc});
	endtask

	task automatic finish_test();
		$display("Errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Random program with expected results noted per instruction
	task automatic gen();
		logic [7:0] k, b;
		logic [2:0] s;
		logic [12:0] y;
		logic [15:0] hl;
		pc = 16'h0000;
		for (int i = 0; i < 60; i++) begin
			k = rnd();
			s = k[6:4];
			hl = {r[4], r[5]};
			case (k[2:0])
				3'h2: begin
					emit(8'hC6 | {k[4:3], 3'h0});
					b = rnd();
					emit(b);
					y = alu({1'b0, k[4:3]}, r[7], b);
					r[7] = y[7:0];
					f = y[12:8];
					note(3'h7, 16'h0000, r[7], 5'd7);
				end
				3'h3: begin
					if (s == 3'h4 || s == 3'h6) begin
						s = 3'h7;
					end
					emit({2'h0, s, 3'h4});
					y = alu(3'h4, r[s], 8'h01);
					r[s] = y[7:0];
					f = y[12:8];
					note(s, 16'h0000, r[s], 5'd4);
				end
				3'h4: begin
					emit(8'h34);
					y = alu(3'h4, img[hl], 8'h01);
					img[hl] = y[7:0];
					f = y[12:8];
					note(3'h6, hl, y[7:0], 5'd10);
				end
				3'h5: begin
					emit(k[3] ? 8'h1A : 8'h0A);
					r[7] = k[3] ? img[{r[2], r[3]}] : img[{r[0], r[1]}];
					note(3'h7, 16'h0000, r[7], 5'd7);
				end
				default: begin
					emit(8'h80 | {k[4:3], s});
					y = alu({1'b0, k[4:3]}, r[7], (s == 3'h6) ? img[hl] : r[s]);
					r[7] = y[7:0];
					f = y[12:8];
					note(3'h7, 16'h0000, r[7], (s == 3'h6) ? 5'd7 : 5'd4);
				end
			endcase
		end
		sp_addr = {8'h40, rnd()};
		emit(8'h22);
		emit(sp_addr[7:0]);
		emit(sp_addr[15:8]);
		note(3'h7, 16'h0000, r[7], 5'd16);
		for (int i = 0; i < 8; i++) begin
			emit(8'h00);
		end
	endtask

	// ----------------------------------------------------------------
	// Clock, timeout and result watcher
	// ----------------------------------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	initial busy = 1'b0;
	always @(negedge sys_clk_i) begin
		cnt++;
		if (instr_done_o === 1'b1) begin
			ndone++;
			if (notes.size() > 0) begin
				nt = notes.pop_front();
				check(16'(cnt), {11'h0, nt.states});
				check(nt.sel == 3'h6 ? u_mem.mem[nt.addr] : regs_o[nt.sel], {8'h00, nt.val});
				check(flags_o, {11'h0, nt.flg});
				check(pc_o, nt.pc);
			end else begin
				check(illegal_op_o, 16'h0001);
			end
		end
		if (cycle_start_o === 1'b1 && (instr_done_o === 1'b1 || !busy)) begin
			cnt = 0;
			busy = 1'b1;
		end else if (instr_done_o === 1'b1) begin
			busy = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		{rstn_i, run_i, reg_load_i, pc_load_i, flags_load_i} = 5'h00;
		reg_load_sel_i = 3'h0;
		reg_load_data_i = 8'h00;
		pc_load_data_i = 16'h0000;
		flags_load_data_i = 5'h00;
		repeat (8) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		for (int i = 0; i < 65536; i++) begin
			put(i[15:0], rnd());
		end
		for (int i = 0; i < 8; i++) begin
			r[i] = (i == 0 || i == 2 || i == 4) ? (8'h80 | (rnd() & 8'h3F)) : rnd();
		end
		f = 5'(rnd());
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_i);
			reg_load_i <= 1'b1;
			reg_load_sel_i <= i[2:0];
			reg_load_data_i <= r[i];
		end
		@(posedge sys_clk_i);
		reg_load_i <= 1'b0;
		flags_load_i <= 1'b1;
		flags_load_data_i <= f;
		pc_load_i <= 1'b1;
		gen();
		@(posedge sys_clk_i);
		flags_load_i <= 1'b0;
		pc_load_i <= 1'b0;
		run_i <= 1'b1;
		while (ndone < 61) begin
			@(posedge sys_clk_i);
		end
		run_i <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		check(u_mem.mem[sp_addr], r[5]);
		check(u_mem.mem[sp_addr + 16'h0001], r[4]);
		check(16'(notes.size()), 16'h0000);
		finish_test();
	end
endmodule
